// ---- pkg/rsa_pkg.sv ----
/*
  Shared constants and types of the remote status and alarm output block.
  Assumes a single 40 MHz controller clock.
*/
package rsa_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_THRESH = 8'h00;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [15:0] THRESH_RST = 16'h0100;
  localparam logic [15:0] DELAY_RST = 16'h03E8;
  localparam int SENSE_LSB = 16;

  // ****************************************
  // Output positions
  // ****************************************
  localparam int NUM_OUT = 12;
  localparam int OUT_RF_ON = 0;
  localparam int OUT_INTLK = 1;
  localparam int OUT_AIR = 2;
  localparam int OUT_SRC = 3;
  localparam int OUT_AUTO_RF = 4;
  localparam int OUT_AUTO_AUD = 5;
  localparam int OUT_MAIN_AUD = 6;
  localparam int OUT_BACK_AUD = 7;
  localparam int OUT_MAINT = 8;
  localparam int OUT_REMOTE = 9;
  localparam int OUT_SUMMARY = 10;
  localparam int OUT_SW_FAULT = 11;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic rf_on;
    logic rf_off;
    logic to_first;
    logic to_second;
    logic auto_rf;
    logic maint;
    logic auto_audio;
    logic main_audio;
    logic backup_audio;
    logic remote_en;
    logic local_only;
  } rsa_cmd_t;
  localparam int CMD_W = 11;

  typedef struct packed {
    logic rf_on;
    logic second_on_air;
    logic backup_src;
    logic auto_rf;
    logic auto_audio;
    logic maint;
    logic remote_en;
  } rsa_mode_t;
  localparam logic [6:0] MODE_RST = 7'h00;

  localparam int SYNC_W = CMD_W + 2 + NUM_OUT;

  typedef enum logic [1:0] {
    RSA_AUD_IDLE = 2'h0,
    RSA_AUD_COUNT = 2'h1,
    RSA_AUD_ALARM = 2'h3
  } rsa_aud_state_t;
endpackage

// ---- sim/rsa_monitor.sv ----
/*
  Model of the external monitoring equipment: a pull-up on every output line.
  Assumes an enable high means the device sinks that line.
*/
`timescale 1ns/10ps
module rsa_monitor (
  input wire logic [11:0] pin_i,
  input wire logic [11:0] pin_oe_i,
  output logic [11:0] level_o
);
  // Open lines float up to the supply, sunk lines follow the driven level
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      level_o[i] = pin_oe_i[i] ? pin_i[i] : 1'b1;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
/*
  Self-checking bench of the remote status and alarm output block.
  Assumes the pull-up monitor model and a tick of 4 clock cycles.
*/
`timescale 1ns/10ps
module tb_top;
  localparam logic [10:0] RF_ON = 11'h400;
  localparam logic [10:0] RF_OFF = 11'h200;
  localparam logic [10:0] TO_FIRST = 11'h100;
  localparam logic [10:0] TO_SECOND = 11'h080;
  localparam logic [10:0] AUTO_RF = 11'h040;
  localparam logic [10:0] MAINT = 11'h020;
  localparam logic [10:0] AUTO_AUD = 11'h010;
  localparam logic [10:0] MAIN_SRC = 11'h008;
  localparam logic [10:0] BACK_SRC = 11'h004;
  localparam logic [10:0] REM_EN = 11'h002;
  localparam logic [10:0] LOCAL_ONLY = 11'h001;
  logic mclk_i;
  logic rst_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [10:0] cmd_v;
  logic [10:0] remote_n;
  logic interlock_open_i;
  logic switch_second_i;
  logic [15:0] main_level_i;
  logic [15:0] backup_level_i;
  logic [1:0] tx_alarm_i;
  logic [11:0] pin_level;
  logic [11:0] alarm_pin_o;
  logic [11:0] alarm_pin_oe_o;
  int errors;
  int checks_done;

  rsa_top #(.LEVEL_W(16), .TICK_CYCLES(4)) dut_u (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .local_cmd_i(rsa_pkg::rsa_cmd_t'(cmd_v)),
    .remote_cmd_n_i(remote_n),
    .interlock_open_i(interlock_open_i),
    .switch_second_i(switch_second_i),
    .main_level_i(main_level_i),
    .backup_level_i(backup_level_i),
    .tx_alarm_i(tx_alarm_i),
    .alarm_pin_i(pin_level),
    .alarm_pin_o(alarm_pin_o),
    .alarm_pin_oe_o(alarm_pin_oe_o)
  );

  rsa_monitor mon_u (
    .pin_i(alarm_pin_o),
    .pin_oe_i(alarm_pin_oe_o),
    .level_o(pin_level)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h instead of %h", $time, seen, exp);
    end
  endtask

  // Line level seen by the monitor: low while asserted
  task automatic pin(input int idx, input logic on);
    check({31'h0, pin_level[idx]}, {31'h0, !on});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // Ends on the edge that takes the pulse
  task automatic cmd(input logic [10:0] v);
    @(posedge mclk_i);
    cmd_v <= v;
    @(posedge mclk_i);
    cmd_v <= 11'h000;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  // Holds one remote pin low long enough to pass the synchroniser
  task automatic remote(input int bitn);
    @(posedge mclk_i);
    remote_n[bitn] <= 1'b0;
    cycles(10);
    remote_n[bitn] <= 1'b1;
    cycles(8);
  endtask

  // Remote pulse meets a local command on the very edge that takes it
  task automatic clash(input int bitn, input logic [10:0] v);
    @(posedge mclk_i);
    remote_n[bitn] <= 1'b0;
    repeat (4) @(posedge mclk_i);
    cmd_v <= v;
    @(posedge mclk_i);
    cmd_v <= 11'h000;
    cycles(5);
    remote_n[bitn] <= 1'b1;
    cycles(8);
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h00000000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cmd_v = 11'h000;
    remote_n = 11'h7FF;
    interlock_open_i = 1'b0;
    switch_second_i = 1'b0;
    main_level_i = 16'h0800;
    backup_level_i = 16'h0800;
    tx_alarm_i = 2'h0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    cycles(8);
    for (int i = 0; i < 12; i++) pin(i, 1'b0);
    check({20'h0, alarm_pin_o}, 32'h00000000);
    reg_read(8'h00, 32'h00000100);
    reg_read(8'h04, 32'h000003E8);
    reg_write(8'h00, 32'hFFFF1234);
    reg_read(8'h00, 32'h00001234);
    reg_read(8'h0C, 32'h00000000);
    reg_write(8'h00, 32'h00000100);
    reg_write(8'h04, 32'h00000003);
    cmd(RF_ON);
    #1;
    pin(0, 1'b0);
    cycles(1);
    pin(0, 1'b1);
    cmd(RF_ON | RF_OFF);
    cycles(2);
    pin(0, 1'b0);
    interlock_open_i <= 1'b1;
    cycles(8);
    pin(1, 1'b1);
    pin(10, 1'b1);
    interlock_open_i <= 1'b0;
    cycles(8);
    pin(1, 1'b0);
    pin(10, 1'b0);
    cmd(TO_SECOND);
    cycles(2);
    pin(2, 1'b1);
    pin(11, 1'b1);
    switch_second_i <= 1'b1;
    cycles(8);
    pin(11, 1'b0);
    cmd(TO_FIRST);
    cycles(2);
    pin(2, 1'b0);
    pin(11, 1'b1);
    switch_second_i <= 1'b0;
    cycles(8);
    pin(11, 1'b0);
    cmd(BACK_SRC);
    cycles(2);
    pin(3, 1'b1);
    cmd(MAIN_SRC);
    cycles(2);
    pin(3, 1'b0);
    cmd(AUTO_RF);
    cycles(2);
    pin(4, 1'b1);
    cmd(MAINT);
    cycles(2);
    pin(8, 1'b1);
    pin(4, 1'b0);
    cmd(AUTO_RF | MAINT);
    cycles(2);
    pin(8, 1'b1);
    cmd(TO_FIRST);
    cycles(2);
    pin(8, 1'b0);
    cmd(AUTO_AUD);
    cycles(2);
    pin(5, 1'b1);
    cmd(MAIN_SRC);
    cycles(2);
    pin(5, 1'b0);
    for (int t = 1; t < 3; t++) begin
      tx_alarm_i <= 2'(t);
      cycles(3);
      pin(10, 1'b1);
      tx_alarm_i <= 2'h0;
      cycles(3);
      pin(10, 1'b0);
    end
    // One level just under the threshold, then exactly at it
    for (int k = 0; k < 2; k++) begin
      if (k == 0) main_level_i <= 16'h00FF;
      else backup_level_i <= 16'h00FF;
      cycles(10);
      pin(6 + k, 1'b0);
      cycles(16);
      pin(6 + k, 1'b1);
      pin(10, 1'b1);
      main_level_i <= 16'h0100;
      backup_level_i <= 16'h0100;
      cycles(3);
      pin(6 + k, 1'b0);
    end
    cmd(RF_OFF);
    cycles(2);
    remote(10);
    pin(0, 1'b0);
    cmd(REM_EN);
    cycles(2);
    pin(9, 1'b1);
    remote(10);
    pin(0, 1'b1);
    remote(9);
    pin(0, 1'b0);
    remote(2);
    pin(3, 1'b1);
    clash(7, TO_FIRST);
    pin(2, 1'b1);
    clash(8, TO_SECOND);
    pin(2, 1'b0);
    cmd(LOCAL_ONLY);
    cycles(2);
    pin(9, 1'b0);
    remote(3);
    pin(3, 1'b1);
    cmd(RF_ON);
    cycles(8);
    reg_read(8'h08, 32'h0FF60009);
    complete_run();
  end
endmodule

// ---- src/rsa_audio_timer.sv ----
/*
  Audio loss qualifier: raises its alarm once the level has stayed below
  the threshold for longer than the delay, counted in tick pulses.
  Assumes level, threshold and tick come from the same clock domain.
*/
`timescale 1ns/10ps
module rsa_audio_timer #(
  parameter int LEVEL_W = 16,
  parameter int DELAY_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [LEVEL_W-1:0] level_i,
  input wire logic [LEVEL_W-1:0] threshold_i,
  input wire logic [DELAY_W-1:0] delay_i,
  output logic alarm_o
);
  rsa_pkg::rsa_aud_state_t state;
  logic [DELAY_W-1:0] cnt;
  logic low;

  assign low = level_i < threshold_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= rsa_pkg::RSA_AUD_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        rsa_pkg::RSA_AUD_IDLE: begin
          cnt <= '0;
          if (low) begin
            state <= rsa_pkg::RSA_AUD_COUNT;
          end
        end
        rsa_pkg::RSA_AUD_COUNT: begin
          if (!low) begin
            state <= rsa_pkg::RSA_AUD_IDLE;
          end else if (tick_i) begin
            // Strictly longer than the delay
            if (cnt >= delay_i) begin
              state <= rsa_pkg::RSA_AUD_ALARM;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        rsa_pkg::RSA_AUD_ALARM: begin
          if (!low) begin
            state <= rsa_pkg::RSA_AUD_IDLE;
          end
        end
        default: begin
          state <= rsa_pkg::RSA_AUD_IDLE;
        end
      endcase
    end
  end

  assign alarm_o = state == rsa_pkg::RSA_AUD_ALARM;

  aud_delay_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $rose(alarm_o) |-> $past(low) && $past(tick_i) && ($past(cnt) >= $past(delay_i)))
    else $error("audio alarm rose before the delay ran out");

  aud_release_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    alarm_o && !low |=> !alarm_o)
    else $error("audio alarm held with acceptable level");
endmodule

// ---- src/rsa_top.sv ----
/*
  Remote alarm and status outputs of a main/standby transfer controller:
  mode state, command arbitration, audio loss timing, open-collector
  outputs and a small register port.
  Assumes remote pins and sensed inputs are asynchronous; local commands,
  audio levels and transmitter alarms are one-cycle or level signals on mclk_i.
*/
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module rsa_top #(
  parameter int LEVEL_W = 16,
  parameter int TICK_CYCLES = rsa_pkg::TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [rsa_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rsa_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rsa_pkg::DATA_W-1:0] reg_rdata_o,
  input wire rsa_pkg::rsa_cmd_t local_cmd_i,
  input wire logic [rsa_pkg::CMD_W-1:0] remote_cmd_n_i,
  input wire logic interlock_open_i,
  input wire logic switch_second_i,
  input wire logic [LEVEL_W-1:0] main_level_i,
  input wire logic [LEVEL_W-1:0] backup_level_i,
  input wire logic [1:0] tx_alarm_i,
  input wire logic [rsa_pkg::NUM_OUT-1:0] alarm_pin_i,
  output logic [rsa_pkg::NUM_OUT-1:0] alarm_pin_o,
  output logic [rsa_pkg::NUM_OUT-1:0] alarm_pin_oe_o
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic at_most_one(input logic [3:0] v);
    at_most_one = (v & (v - 4'h1)) == 4'h0;
  endfunction

  function automatic logic [3:0] pick(input logic [3:0] loc, input logic [3:0] rem,
                                      input logic use_rem);
    pick = (use_rem && (rem != 4'h0)) ? rem : loc;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [rsa_pkg::SYNC_W-1:0] sync1;
  logic [rsa_pkg::SYNC_W-1:0] sync2;
  logic [rsa_pkg::SYNC_W-1:0] sync3;
  logic [rsa_pkg::SYNC_W-1:0] clean;
  logic [rsa_pkg::SYNC_W-1:0] raw_in;

  assign raw_in = {~remote_cmd_n_i, interlock_open_i, switch_second_i, alarm_pin_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A bit changes only once the last two stages agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clean <= '0;
    end else begin
      for (int i = 0; i < rsa_pkg::SYNC_W; i++) begin
        if (sync2[i] == sync3[i]) begin
          clean[i] <= sync3[i];
        end
      end
    end
  end

  rsa_pkg::rsa_cmd_t rem_level;
  rsa_pkg::rsa_cmd_t rem_prev;
  rsa_pkg::rsa_cmd_t rem_cmd;
  logic intlk_open;
  logic sw_second;
  logic [rsa_pkg::NUM_OUT-1:0] pin_sense;

  assign rem_level = rsa_pkg::rsa_cmd_t'(clean[rsa_pkg::SYNC_W-1 -: rsa_pkg::CMD_W]);
  assign intlk_open = clean[rsa_pkg::NUM_OUT+1];
  assign sw_second = clean[rsa_pkg::NUM_OUT];
  assign pin_sense = clean[rsa_pkg::NUM_OUT-1:0];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_prev <= rsa_pkg::rsa_cmd_t'(11'h000);
    end else begin
      rem_prev <= rem_level;
    end
  end

  // Remote inputs act on assertion; remote cannot change its own enable
  always_comb begin
    rem_cmd = rem_level & ~rem_prev;
    rem_cmd.remote_en = 1'b0;
    rem_cmd.local_only = 1'b0;
  end

  // ****************************************
  // Command arbitration
  // ****************************************
  rsa_pkg::rsa_mode_t mode;
  logic use_rem;
  logic [3:0] rf_grp;
  logic [3:0] aud_grp;
  logic [1:0] pwr_grp;
  logic rf_ok;
  logic aud_ok;

  // Remote wins per group when enabled and active
  // Remote ignored in local-only mode
  assign use_rem = mode.remote_en;
  assign rf_grp = pick({local_cmd_i.to_first, local_cmd_i.to_second,
                        local_cmd_i.auto_rf, local_cmd_i.maint},
                       {rem_cmd.to_first, rem_cmd.to_second,
                        rem_cmd.auto_rf, rem_cmd.maint}, use_rem);
  assign aud_grp = pick({1'b0, local_cmd_i.auto_audio, local_cmd_i.main_audio,
                         local_cmd_i.backup_audio},
                        {1'b0, rem_cmd.auto_audio, rem_cmd.main_audio,
                         rem_cmd.backup_audio}, use_rem);
  assign pwr_grp = (use_rem && (rem_cmd.rf_on || rem_cmd.rf_off)) ?
                   {rem_cmd.rf_on, rem_cmd.rf_off} :
                   {local_cmd_i.rf_on, local_cmd_i.rf_off};
  // Several commands of the RF or audio group together do nothing
  assign rf_ok = at_most_one(rf_grp);
  assign aud_ok = at_most_one(aud_grp);

  // ****************************************
  // Audio loss timing
  // ****************************************
  logic [15:0] thresh;
  logic [15:0] delay;
  logic [15:0] tick_cnt;
  logic tick;
  logic main_alarm;
  logic backup_alarm;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 16'(TICK_CYCLES - 1);
      if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
        tick_cnt <= 16'h0000;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  rsa_audio_timer #(
    .LEVEL_W(LEVEL_W),
    .DELAY_W(16)
  ) main_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .level_i(main_level_i),
    .threshold_i(LEVEL_W'(thresh)),
    .delay_i(delay),
    .alarm_o(main_alarm)
  );

  rsa_audio_timer #(
    .LEVEL_W(LEVEL_W),
    .DELAY_W(16)
  ) backup_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .level_i(backup_level_i),
    .threshold_i(LEVEL_W'(thresh)),
    .delay_i(delay),
    .alarm_o(backup_alarm)
  );

  // ****************************************
  // System mode
  // ****************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= rsa_pkg::rsa_mode_t'(rsa_pkg::MODE_RST);
    end else begin
      // RF off has priority over RF on
      if (pwr_grp[0]) begin
        mode.rf_on <= 1'b0;
      end else if (pwr_grp[1]) begin
        mode.rf_on <= 1'b1;
      end
      if (rf_ok && (rf_grp[3] || rf_grp[2])) begin
        mode.second_on_air <= rf_grp[2];
        mode.auto_rf <= 1'b0;
        mode.maint <= 1'b0;
      end else if (rf_ok && rf_grp[1]) begin
        mode.auto_rf <= 1'b1;
        mode.maint <= 1'b0;
      end else if (rf_ok && rf_grp[0]) begin
        mode.maint <= 1'b1;
        mode.auto_rf <= 1'b0;
      end else if (pwr_grp[0]) begin
        mode.maint <= 1'b0;
      end
      if (aud_ok && (aud_grp[1] || aud_grp[0])) begin
        mode.backup_src <= aud_grp[0];
        mode.auto_audio <= 1'b0;
      end else if (aud_ok && aud_grp[2]) begin
        mode.auto_audio <= 1'b1;
      end else if (mode.auto_audio) begin
        // Automatic audio falls back to backup only when backup is good
        if (!main_alarm) begin
          mode.backup_src <= 1'b0;
        end else if (!backup_alarm) begin
          mode.backup_src <= 1'b1;
        end
      end
      // Remote enable is changed from the local side only
      if (local_cmd_i.local_only) begin
        mode.remote_en <= 1'b0;
      end else if (local_cmd_i.remote_en) begin
        mode.remote_en <= 1'b1;
      end
    end
  end

  // ****************************************
  // Alarm and status outputs
  // ****************************************
  logic [rsa_pkg::NUM_OUT-1:0] next_assert;
  logic sw_fault;
  logic any_alarm;

  assign sw_fault = sw_second != mode.second_on_air;
  assign any_alarm = intlk_open || main_alarm || backup_alarm || sw_fault ||
                     (tx_alarm_i != 2'h0);

  always_comb begin
    next_assert = '0;
    next_assert[rsa_pkg::OUT_RF_ON] = mode.rf_on;
    next_assert[rsa_pkg::OUT_INTLK] = intlk_open;
    next_assert[rsa_pkg::OUT_AIR] = mode.second_on_air;
    next_assert[rsa_pkg::OUT_SRC] = mode.backup_src;
    next_assert[rsa_pkg::OUT_AUTO_RF] = mode.auto_rf;
    next_assert[rsa_pkg::OUT_AUTO_AUD] = mode.auto_audio;
    next_assert[rsa_pkg::OUT_MAIN_AUD] = main_alarm;
    next_assert[rsa_pkg::OUT_BACK_AUD] = backup_alarm;
    next_assert[rsa_pkg::OUT_MAINT] = mode.maint;
    next_assert[rsa_pkg::OUT_REMOTE] = mode.remote_en;
    next_assert[rsa_pkg::OUT_SUMMARY] = any_alarm;
    next_assert[rsa_pkg::OUT_SW_FAULT] = sw_fault;
  end

  // Asserted means sink to ground, released means open collector
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_pin_oe_o <= '0;
      alarm_pin_o <= '0;
    end else begin
      alarm_pin_oe_o <= next_assert;
      alarm_pin_o <= '0;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thresh <= rsa_pkg::THRESH_RST;
      delay <= rsa_pkg::DELAY_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == rsa_pkg::REG_THRESH) begin
        thresh <= reg_wdata_i[15:0];
      end else if (reg_addr_i == rsa_pkg::REG_DELAY) begin
        delay <= reg_wdata_i[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == rsa_pkg::REG_THRESH) begin
        reg_rdata_o <= {16'h0000, thresh};
      end else if (reg_addr_i == rsa_pkg::REG_DELAY) begin
        reg_rdata_o <= {16'h0000, delay};
      end else if (reg_addr_i == rsa_pkg::REG_STATUS) begin
        reg_rdata_o <= {4'h0, pin_sense, 4'h0, alarm_pin_oe_o};
      end else begin
        reg_rdata_o <= '0;
      end
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  open_drain_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (alarm_pin_oe_o != 12'h000) |-> (alarm_pin_o == 12'h000))
    else $error("asserted output not sinking low");

  rf_status_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    pwr_grp[0] |=> ##1 !alarm_pin_oe_o[rsa_pkg::OUT_RF_ON])
    else $error("rf-on status not released after rf off");

  intlk_alarm_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    intlk_open |=> alarm_pin_oe_o[rsa_pkg::OUT_INTLK] &&
                   alarm_pin_oe_o[rsa_pkg::OUT_SUMMARY])
    else $error("interlock open not reported");

  air_status_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rf_ok && rf_grp[2] |=> ##1 alarm_pin_oe_o[rsa_pkg::OUT_AIR])
    else $error("second transmitter on air not reported");

  audio_src_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    aud_ok && aud_grp[1] |=> ##1 !alarm_pin_oe_o[rsa_pkg::OUT_SRC] &&
                             !alarm_pin_oe_o[rsa_pkg::OUT_AUTO_AUD])
    else $error("main source select not reported");

  maint_clear_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rf_ok && rf_grp[3] |=> ##1 !alarm_pin_oe_o[rsa_pkg::OUT_MAINT] &&
                           !alarm_pin_oe_o[rsa_pkg::OUT_AUTO_RF])
    else $error("maintenance or auto rf held after manual select");

  remote_ignore_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !mode.remote_en && (local_cmd_i == 11'h000) |=>
      $stable({mode.rf_on, mode.second_on_air, mode.auto_rf, mode.auto_audio, mode.maint,
               mode.remote_en}) && ($past(mode.auto_audio) || $stable(mode.backup_src)))
    else $error("remote command acted in local-only mode");

  remote_prio_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    mode.remote_en && rem_cmd.to_second && !rem_cmd.to_first && !rem_cmd.auto_rf &&
    !rem_cmd.maint && local_cmd_i.to_first |=> mode.second_on_air)
    else $error("local command beat remote command");

  summary_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tx_alarm_i != 2'h0) |=> alarm_pin_oe_o[rsa_pkg::OUT_SUMMARY])
    else $error("transmitter alarm missing from summary");

  sw_fault_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ##1 alarm_pin_oe_o[rsa_pkg::OUT_SW_FAULT] ==
        ($past(sw_second) != $past(mode.second_on_air)))
    else $error("switch fault does not match routing one clock later");
endmodule
